// file: hdl/stap_consts.svh
/*
 Register widths, reset values and instruction codes for the SRAM test port.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef STAP_CONSTS_SVH
`define STAP_CONSTS_SVH
`define STAP_IR_WIDTH      3
`define STAP_BSR_LEN       72
`define STAP_ID_WIDTH      32
`define STAP_IR_EXTEST     3'h0
`define STAP_IR_IDCODE     3'h1
`define STAP_IR_SAMPLEZ    3'h2
`define STAP_IR_SAMPLE     3'h4
`define STAP_IR_BYPASS     3'h7
`define STAP_IR_CAPTURE    3'h1
// Arbitrary neutral identification value
`define STAP_ID_VALUE      32'h0000_0001
`define STAP_PLACEHOLDER   1'b0
`endif

// file: hdl/stap_pkg.sv
/*
 Types for the SRAM test port: TAP states and decoded instructions.
 Assumes the constants header is on the include path.
*/
`include "stap_consts.svh"
package stap_pkg;
    typedef enum logic [3:0]
    {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR   = 4'hc,
        ST_SEL_IR   = 4'hd,
        ST_CAP_IR   = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EXIT1_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR   = 4'h8
    } stap_state_t;
    typedef enum logic [1:0]
    {
        SEL_BYPASS = 2'h0,
        SEL_ID     = 2'h1,
        SEL_BSR    = 2'h2
    } stap_dr_sel_t;
endpackage

// file: hdl/stap_tck_if.sv
/*
 Carrier for TCK events and synchronised TAP pins between modules.
 Assumes one clk_sys domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface stap_tck_if;
    logic tckRise;
    logic tckFall;
    logic tmsSync;
    logic tdiSync;
    modport src (output tckRise, output tckFall, output tmsSync,
                 output tdiSync);
    modport dst (input tckRise, input tckFall, input tmsSync,
                 input tdiSync);
endinterface
`default_nettype wire

// file: hdl/stap_pin_sync.sv
/*
 Two-stage synchronisers for TCK, TMS and TDI plus TCK edge detection.
 Assumes pins are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module stap_pin_sync
(
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   tck,
    input  wire logic   tms,
    input  wire logic   tdi,
    stap_tck_if.src     evt
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic       tckLast_reg;
    logic       armed_reg;

    // Chain keeps sampling in reset so it never holds a made-up level
    always_ff @(posedge clk_sys)
    begin
        meta_reg    <= {tck, tms, tdi};
        sync_reg    <= meta_reg;
        tckLast_reg <= sync_reg[2];
    end

    // No false TCK edge right after reset, whatever the idle level
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            armed_reg <= 1'b0;
        else
            armed_reg <= 1'b1;
    end

    assign evt.tckRise = armed_reg & sync_reg[2] & ~tckLast_reg;
    assign evt.tckFall = armed_reg & ~sync_reg[2] & tckLast_reg;
    assign evt.tmsSync = sync_reg[1];
    assign evt.tdiSync = sync_reg[0];
endmodule
`default_nettype wire

// file: hdl/stap_top.sv
/*
 TAP instruction execution for the SRAM: state machine, instruction,
 bypass, ID and 72-cell observe-only boundary register, TDO on TCK fall.
 Assumes pad levels are quasi-static inputs asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stap_consts.svh"
module stap_top
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdoOe_n,
    output logic             sramOutHiz,
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  data_lane_a,
    input  wire logic [7:0]  data_lane_b,
    input  wire logic [7:0]  data_lane_c,
    input  wire logic [7:0]  data_lane_d,
    input  wire logic        parity_lane_a,
    input  wire logic        parity_lane_b,
    input  wire logic        parity_lane_c,
    input  wire logic        parity_lane_d,
    input  wire logic        snooze_input,
    input  wire logic        advance_load_input,
    input  wire logic        outEnable_n,
    input  wire logic        clkEnable_n,
    input  wire logic        write_n,
    input  wire logic        sramClk,
    input  wire logic        chip_enable3_n,
    input  wire logic        byteWriteLaneA_n,
    input  wire logic        byte_write_lane_b_n,
    input  wire logic        byte_write_lane_c_n,
    input  wire logic        byte_write_lane_d_n,
    input  wire logic        chip_enable2,
    input  wire logic        chip_enable1_n,
    input  wire logic        burst_order_select_n
);
    stap_tck_if evt ();

    stap_pin_sync u_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tck     (tck),
        .tms     (tms),
        .tdi     (tdi),
        .evt     (evt)
    );

    // ------------------------------------------------------------
    // Pad snapshot in scan order, cell 71 first
    // ------------------------------------------------------------
    logic [`STAP_BSR_LEN-1:0] padVec;
    logic [`STAP_BSR_LEN-1:0] padMeta_reg;
    logic [`STAP_BSR_LEN-1:0] padSync_reg;

    assign padVec =
    {
        addr[0], addr[1], addr[3], addr[2], addr[5], addr[4],
        burst_order_select_n, parity_lane_d,
        data_lane_d[0], data_lane_d[1], data_lane_d[2], data_lane_d[3],
        data_lane_d[4], data_lane_d[5], data_lane_d[6], data_lane_d[7],
        `STAP_PLACEHOLDER, `STAP_PLACEHOLDER,
        data_lane_c[0], data_lane_c[1], data_lane_c[2], data_lane_c[3],
        data_lane_c[4], data_lane_c[5], data_lane_c[6], data_lane_c[7],
        parity_lane_c, addr[6], addr[7],
        chip_enable1_n, chip_enable2, byte_write_lane_d_n,
        byte_write_lane_c_n, byte_write_lane_b_n, byteWriteLaneA_n,
        chip_enable3_n, sramClk, write_n, clkEnable_n, outEnable_n,
        advance_load_input,
        addr[18], addr[17], addr[9], addr[8], parity_lane_b,
        data_lane_b[0], data_lane_b[1], data_lane_b[2], data_lane_b[3],
        data_lane_b[4], data_lane_b[5], data_lane_b[6], data_lane_b[7],
        `STAP_PLACEHOLDER, snooze_input,
        data_lane_a[0], data_lane_a[1], data_lane_a[2], data_lane_a[3],
        data_lane_a[4], data_lane_a[5], data_lane_a[6], data_lane_a[7],
        parity_lane_a,
        addr[10], addr[12], addr[11], addr[14], addr[13], addr[16],
        addr[15]
    };

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            padMeta_reg <= '0;
            padSync_reg <= '0;
        end
        else
        begin
            padMeta_reg <= padVec;
            padSync_reg <= padMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // TAP state machine
    // ------------------------------------------------------------
    stap_pkg::stap_state_t state_reg;
    stap_pkg::stap_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            stap_pkg::ST_RESET:    state_next = evt.tmsSync ?
                stap_pkg::ST_RESET : stap_pkg::ST_IDLE;
            stap_pkg::ST_IDLE:     state_next = evt.tmsSync ?
                stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            stap_pkg::ST_SEL_DR:   state_next = evt.tmsSync ?
                stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
            stap_pkg::ST_CAP_DR:   state_next = evt.tmsSync ?
                stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_SHIFT_DR: state_next = evt.tmsSync ?
                stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_EXIT1_DR: state_next = evt.tmsSync ?
                stap_pkg::ST_UPD_DR : stap_pkg::ST_PAUSE_DR;
            stap_pkg::ST_PAUSE_DR: state_next = evt.tmsSync ?
                stap_pkg::ST_EXIT2_DR : stap_pkg::ST_PAUSE_DR;
            stap_pkg::ST_EXIT2_DR: state_next = evt.tmsSync ?
                stap_pkg::ST_UPD_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_UPD_DR:   state_next = evt.tmsSync ?
                stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            stap_pkg::ST_SEL_IR:   state_next = evt.tmsSync ?
                stap_pkg::ST_RESET : stap_pkg::ST_CAP_IR;
            stap_pkg::ST_CAP_IR:   state_next = evt.tmsSync ?
                stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_SHIFT_IR: state_next = evt.tmsSync ?
                stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_EXIT1_IR: state_next = evt.tmsSync ?
                stap_pkg::ST_UPD_IR : stap_pkg::ST_PAUSE_IR;
            stap_pkg::ST_PAUSE_IR: state_next = evt.tmsSync ?
                stap_pkg::ST_EXIT2_IR : stap_pkg::ST_PAUSE_IR;
            stap_pkg::ST_EXIT2_IR: state_next = evt.tmsSync ?
                stap_pkg::ST_UPD_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_UPD_IR:   state_next = evt.tmsSync ?
                stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            default:               state_next = stap_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_reg <= stap_pkg::ST_RESET;
        else if (evt.tckRise)
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // Instruction shift and active instruction
    // ------------------------------------------------------------
    logic [`STAP_IR_WIDTH-1:0] irShift_reg;
    logic [`STAP_IR_WIDTH-1:0] irActive_reg;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irShift_reg <= `STAP_IR_CAPTURE;
        else if (evt.tckRise && state_reg == stap_pkg::ST_CAP_IR)
            irShift_reg <= `STAP_IR_CAPTURE;
        else if (evt.tckRise && state_reg == stap_pkg::ST_SHIFT_IR)
            irShift_reg <= {evt.tdiSync,
                            irShift_reg[`STAP_IR_WIDTH-1:1]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irActive_reg <= `STAP_IR_IDCODE;
        else if (state_reg == stap_pkg::ST_RESET)
            irActive_reg <= `STAP_IR_IDCODE;
        else if (evt.tckFall && state_reg == stap_pkg::ST_UPD_IR)
            irActive_reg <= irShift_reg;
    end

    // ------------------------------------------------------------
    // Decode: reserved codes fall back to bypass
    // ------------------------------------------------------------
    stap_pkg::stap_dr_sel_t drSel;
    logic                   hizWanted;

    always_comb
    begin
        drSel     = stap_pkg::SEL_BYPASS;
        hizWanted = 1'b0;
        case (irActive_reg)
            `STAP_IR_EXTEST:
            begin
                drSel     = stap_pkg::SEL_BSR;
                hizWanted = 1'b1;
            end
            `STAP_IR_IDCODE:  drSel = stap_pkg::SEL_ID;
            `STAP_IR_SAMPLEZ:
            begin
                drSel     = stap_pkg::SEL_BSR;
                hizWanted = 1'b1;
            end
            `STAP_IR_SAMPLE:  drSel = stap_pkg::SEL_BSR;
            default:          drSel = stap_pkg::SEL_BYPASS;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            sramOutHiz <= 1'b0;
        else
            sramOutHiz <= hizWanted;
    end

    // ------------------------------------------------------------
    // Data registers: observe-only, no update latch
    // ------------------------------------------------------------
    logic                      bypass_reg;
    logic [`STAP_ID_WIDTH-1:0] id_reg;
    logic [`STAP_BSR_LEN-1:0]  bsr_reg;
    logic                      capDr;
    logic                      shDr;

    assign capDr = evt.tckRise && state_reg == stap_pkg::ST_CAP_DR;
    assign shDr  = evt.tckRise && state_reg == stap_pkg::ST_SHIFT_DR;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            bypass_reg <= 1'b0;
        else if (capDr && drSel == stap_pkg::SEL_BYPASS)
            bypass_reg <= 1'b0;
        else if (shDr && drSel == stap_pkg::SEL_BYPASS)
            bypass_reg <= evt.tdiSync;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            id_reg <= `STAP_ID_VALUE;
        else if (capDr && drSel == stap_pkg::SEL_ID)
            id_reg <= `STAP_ID_VALUE;
        else if (shDr && drSel == stap_pkg::SEL_ID)
            id_reg <= {evt.tdiSync, id_reg[`STAP_ID_WIDTH-1:1]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            bsr_reg <= '0;
        else if (capDr && drSel == stap_pkg::SEL_BSR)
            bsr_reg <= padSync_reg;
        else if (shDr && drSel == stap_pkg::SEL_BSR)
            bsr_reg <= {evt.tdiSync,
                        bsr_reg[`STAP_BSR_LEN-1:1]};
    end

    // ------------------------------------------------------------
    // TDO launched on TCK fall
    // ------------------------------------------------------------
    logic tdoBit;

    always_comb
    begin
        tdoBit = bypass_reg;
        if (state_reg == stap_pkg::ST_SHIFT_IR)
            tdoBit = irShift_reg[0];
        else if (drSel == stap_pkg::SEL_ID)
            tdoBit = id_reg[0];
        else if (drSel == stap_pkg::SEL_BSR)
            tdoBit = bsr_reg[0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tdo     <= 1'b0;
            tdoOe_n <= 1'b1;
        end
        else if (evt.tckFall)
        begin
            tdo     <= tdoBit;
            tdoOe_n <= ~(state_reg == stap_pkg::ST_SHIFT_IR ||
                         state_reg == stap_pkg::ST_SHIFT_DR);
        end
    end
endmodule
`default_nettype wire

// file: tb/stap_top_asserts.sv
/*
 Checker for TAP output timing, reset values and test-logic reset.
 Assumes raw TAP pins that change well clear of clk_sys edges.
*/
`timescale 1ns/1ps
`default_nettype none
module stap_top_asserts
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdo,
    input  wire logic tdoOe_n,
    input  wire logic sramOutHiz
);
    logic [3:0] sinceFall_reg;
    logic [3:0] sinceRise_reg;
    logic [2:0] highRises_reg;
    logic       lastTms_reg;
    logic       tckQ_reg;
    always_ff @(posedge clk_sys)
        tckQ_reg <= tck;
    always_ff @(posedge clk_sys)
    begin
        if (rst || (tckQ_reg && !tck))
            sinceFall_reg <= 4'h0;
        else if (sinceFall_reg != 4'hf)
            sinceFall_reg <= sinceFall_reg + 4'h1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst || (!tckQ_reg && tck))
            sinceRise_reg <= 4'h0;
        else if (sinceRise_reg != 4'hf)
            sinceRise_reg <= sinceRise_reg + 4'h1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            highRises_reg <= 3'h0;
        else if (!tckQ_reg && tck)
            highRises_reg <= !tms ? 3'h0 :
                (highRises_reg == 3'h5 ? 3'h5 : highRises_reg + 3'h1);
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            lastTms_reg <= 1'b1;
        else if (!tckQ_reg && tck)
            lastTms_reg <= tms;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_near_fall;
        sinceFall_reg <= 4'h6;
    endsequence
    // Hi-z drops on the rise that enters test-logic reset
    sequence s_near_tlr;
        sinceRise_reg <= 4'h6 && lastTms_reg && !sramOutHiz;
    endsequence
    sequence s_idcode_back;
        ##[0:12] !sramOutHiz;
    endsequence
    a_tdo_after_fall: assert property ($changed(tdo) |-> s_near_fall)
        else $error("tdo moved away from a tck fall");
    a_oe_after_fall: assert property ($changed(tdoOe_n) |-> s_near_fall)
        else $error("tdo enable moved away from a tck fall");
    a_hiz_near_edge: assert property ($changed(sramOutHiz) |->
        (s_near_fall or s_near_tlr))
        else $error("hiz moved away from an update or reset edge");
    a_oe_enter_shift: assert property ($fell(tdoOe_n) |-> !lastTms_reg)
        else $error("tdo enabled without a shift entry");
    a_oe_leave_shift: assert property ($rose(tdoOe_n) |-> lastTms_reg)
        else $error("tdo disabled while still shifting");
    a_hiz_on_update: assert property ($changed(sramOutHiz) |-> lastTms_reg)
        else $error("hiz changed outside an update");
    a_tlr_idcode: assert property (highRises_reg == 3'h5 |-> s_idcode_back)
        else $error("hiz still set after test logic reset");
    a_reset_values: assert property ($fell(rst) |->
        (tdoOe_n && !tdo && !sramOutHiz))
        else $error("outputs not at reset values");
endmodule
bind stap_top stap_top_asserts u_chk
(
    .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo),
    .tdoOe_n(tdoOe_n), .sramOutHiz(sramOutHiz)
);
`default_nettype wire

// file: tb/stap_jtag_host.sv
/*
 Boundary-scan controller model: drives tck, tms and tdi, reads tdo.
 Assumes clk_sys at 50 ns; tck runs 400 ns only inside sequences.
*/
`timescale 1ns/1ps
`default_nettype none
module stap_jtag_host
(
    input  wire logic clk_sys,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdoOe_n,
    input  wire logic sramOutHiz
);
    logic hizPre;
    logic lastOe;
    int   oeOff;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        hizPre = 1'b0;
        lastOe = 1'b1;
        oeOff = 0;
    end
    // One tck period; tdo taken just before the fall
    task automatic bit_cyc(input logic m, input logic d, output logic q);
        @(posedge clk_sys);
        #1;
        tms = m;
        tdi = d;
        repeat (3) @(posedge clk_sys);
        #1;
        tck = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        q = tdo;
        lastOe = tdoOe_n;
        tck = 1'b0;
    endtask
    task automatic tap_reset();
        logic q;
        repeat (5) bit_cyc(1'b1, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
    endtask
    task automatic shift_ir(input logic [2:0] code, output logic [2:0] old);
        logic q;
        bit_cyc(1'b1, 1'b1, q);
        bit_cyc(1'b1, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
        for (int i = 0; i < 3; i++)
        begin
            bit_cyc(i == 2, code[i], q);
            old[i] = q;
        end
        hizPre = sramOutHiz;
        bit_cyc(1'b1, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
    endtask
    task automatic shift_dr(input int n, input logic [71:0] din,
                            output logic [71:0] dout);
        logic q;
        dout = '0;
        bit_cyc(1'b1, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            bit_cyc(i == n - 1, din[i], q);
            dout[i] = q;
            if (lastOe !== 1'b0)
                oeOff++;
        end
        bit_cyc(1'b1, 1'b1, q);
        bit_cyc(1'b0, 1'b1, q);
    endtask
endmodule
`default_nettype wire

// file: tb/stap_top_bench.sv
/*
 Self-checking bench for the SRAM test port with a scan controller model.
 Assumes the constants header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stap_consts.svh"
module stap_top_bench;
    logic        clk_sys;
    logic        rst;
    logic        tck, tms, tdi, tdo, tdoOe_n, sramOutHiz;
    logic [18:0] addr;
    logic [3:0]  ln;
    logic [3:0]  par;
    logic [13:0] ctl;
    int          bad_count;
    int          checks;
    stap_top dut
    (
        .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoOe_n(tdoOe_n), .sramOutHiz(sramOutHiz), .addr(addr),
        .data_lane_a({8{ln[0]}}), .data_lane_b({8{ln[1]}}),
        .data_lane_c({8{ln[2]}}), .data_lane_d({8{ln[3]}}),
        .parity_lane_a(par[0]), .parity_lane_b(par[1]),
        .parity_lane_c(par[2]), .parity_lane_d(par[3]),
        .snooze_input(ctl[0]), .advance_load_input(ctl[1]),
        .outEnable_n(ctl[2]), .clkEnable_n(ctl[3]), .write_n(ctl[4]),
        .sramClk(ctl[5]), .chip_enable3_n(ctl[6]), .byteWriteLaneA_n(ctl[7]),
        .byte_write_lane_b_n(ctl[8]), .byte_write_lane_c_n(ctl[9]),
        .byte_write_lane_d_n(ctl[10]), .chip_enable2(ctl[11]),
        .chip_enable1_n(ctl[12]), .burst_order_select_n(ctl[13])
    );
    stap_jtag_host host
    (
        .clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe_n(tdoOe_n), .sramOutHiz(sramOutHiz)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [71:0] e,
                       input logic [71:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic set_pads(input logic k);
        @(posedge clk_sys);
        #1;
        addr = 19'h5a3c6 ^ {19{k}};
        ln = 4'h5 ^ {4{k}};
        par = 4'h6 ^ {4{k}};
        ctl = 14'h2d39 ^ {14{k}};
    endtask
    // Expected chain, cell 71 first
    function automatic logic [71:0] bsr_exp();
        return {addr[0], addr[1], addr[3], addr[2], addr[5], addr[4],
                ctl[13], par[3], {8{ln[3]}}, 2'h0, {8{ln[2]}}, par[2],
                addr[6], addr[7], ctl[12:1], addr[18], addr[17], addr[9],
                addr[8], par[1], {8{ln[1]}}, 1'b0, ctl[0], {8{ln[0]}},
                par[0], addr[10], addr[12], addr[11], addr[14], addr[13],
                addr[16], addr[15]};
    endfunction
    task automatic read_id();
        logic        q;
        logic [71:0] d;
        // One TMS-low clock leaves test-logic reset for idle
        host.bit_cyc(1'b0, 1'b1, q);
        host.shift_dr(32, {72{1'b1}}, d);
        chk("idcode", {40'h0, `STAP_ID_VALUE}, d);
    endtask
    task automatic t_bypass();
        logic [2:0]  o;
        logic [71:0] d;
        host.shift_ir(`STAP_IR_BYPASS, o);
        chk("ir capture", {69'h0, `STAP_IR_CAPTURE}, {69'h0, o});
        host.shift_dr(4, 72'hb, d);
        chk("bypass", 72'h6, d);
        $display("test bypass done");
    endtask
    task automatic t_bsr();
        logic [2:0]  codes [3] = '{`STAP_IR_SAMPLE, `STAP_IR_EXTEST,
                                   `STAP_IR_SAMPLEZ};
        logic [2:0]  hz = 3'b110;
        logic        prev = 1'b0;
        logic [2:0]  o;
        logic [71:0] d;
        for (int i = 0; i < 3; i++)
        begin
            set_pads(i[0]);
            host.shift_ir(codes[i], o);
            chk("hiz before update", {71'h0, prev}, {71'h0, host.hizPre});
            chk("hiz", {71'h0, hz[i]}, {71'h0, sramOutHiz});
            host.shift_dr(72, 72'h0, d);
            chk("boundary", bsr_exp(), d);
            chk("hiz after dr", {71'h0, hz[i]}, {71'h0, sramOutHiz});
            prev = hz[i];
        end
        $display("test boundary done");
    endtask
    task automatic t_resets();
        logic [2:0] o;
        host.tap_reset();
        chk("hiz after tms reset", 72'h0, {71'h0, sramOutHiz});
        read_id();
        host.shift_ir(`STAP_IR_EXTEST, o);
        chk("hiz extest", 72'h1, {71'h0, sramOutHiz});
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("hiz after reset", 72'h0, {71'h0, sramOutHiz});
        read_id();
        chk("oe off in shift", 72'h0, 72'(host.oeOff));
        $display("test resets done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        bad_count = 0;
        checks = 0;
        rst = 1'b1;
        addr = '0;
        ln = '0;
        par = '0;
        ctl = '0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        read_id();
        $display("test id default done");
        t_bypass();
        t_bsr();
        t_resets();
        tally_and_finish();
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
